/* rtl/rccr_channel_regs.v */
// Operation
// - mode 00 hi-z, mode 11 fixed 50 ohm
// - mode 01 polls every 12 ms, 50 tries
// - mode 10 polls every 12 ms forever
// - auto modes hi-z until detect, then 50
// - 0x08 bit 3 hands mode to register
// - assert threshold bits 3:2, default 00
// - de-assert threshold bits 1:0, default 00
// - 0x08 bit 6 hands thresholds to register
// - 8-bit equalizer register resets to 0x2F
// - swing bit 7 short-circuit protect, reset 0xAD
// - swing bits 2:0 select amplitude ratio
`include "rccr_regs.vh"
module rccr_channel_regs #(
   parameter POLL_CYC = `RCCR_POLL_CYC,
   parameter POLL_TRIES = `RCCR_POLL_TRIES
) (
   input wire mclk_i,
   input wire nrst_i,
   input wire wr_en_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   output reg [7:0] rdata_o,
   input wire receiver_detect_mode_ovr_i,
   input wire sdth_ovr_i,
   input wire [1:0] receiver_detect_mode_pin_i,
   input wire [3:0] sdth_pin_i,
   input wire rx_present_i,
   output reg [3:0] ch4_sdth_o,
   output reg term_50_o,
   output reg detect_test_o,
   output reg [7:0] ch5_eq_o,
   output reg scp_en_o,
   output reg [2:0] swing_ratio_o
);
   localparam S_IDLE = 2'd0;
   localparam S_WAIT = 2'd1;
   localparam S_DONE = 2'd2;
   localparam S_STOP = 2'd3;
   reg [7:0] ch4_sdth_reg;
   reg [7:0] rsvd_a_reg;
   reg [7:0] rsvd_b_reg;
   reg [7:0] ch5_rxdm_reg;
   reg [7:0] ch5_eq_reg;
   reg [7:0] ch5_swing_reg;
   reg [1:0] state_reg;
   reg [1:0] mode_q_reg;
   reg [31:0] tmr_reg;
   reg [7:0] tries_reg;
   reg [7:0] rdata_next;
   wire [1:0] receiver_detect_mode_pin_s;
   wire [3:0] sdth_pin_s;
   wire present_s;
   wire [1:0] mode;
   wire [3:0] sdth_eff;
   wire [2:0] ratio_field;
   wire poll_end;
   wire auto_mode;
   wire tries_spent;
   // pins are asynchronous to the register clock
   rccr_sync2 #(.W(7)) u_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .d_i({rx_present_i, sdth_pin_i, receiver_detect_mode_pin_i}),
      .q_o({present_s, sdth_pin_s, receiver_detect_mode_pin_s})
   );
   assign mode = receiver_detect_mode_ovr_i ?
      ch5_rxdm_reg[`RCCR_RXDM_MSB:`RCCR_RXDM_LSB] : receiver_detect_mode_pin_s;
   // register thresholds only once software owns them, the pin otherwise
   assign sdth_eff = sdth_ovr_i ?
      ch4_sdth_reg[`RCCR_SDTH_ASSERT_MSB:`RCCR_SDTH_DEASSERT_LSB] :
      sdth_pin_s;
   assign ratio_field =
      ch5_swing_reg[`RCCR_SWING_RATIO_MSB:`RCCR_SWING_RATIO_LSB];
   assign poll_end = (tmr_reg == POLL_CYC - 1);
   assign auto_mode = (mode == `RCCR_RXDM_AUTO_LIM) ||
      (mode == `RCCR_RXDM_AUTO_INF);
   assign tries_spent = (mode == `RCCR_RXDM_AUTO_LIM) &&
      (tries_reg == POLL_TRIES - 1);
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         ch4_sdth_reg <= `RCCR_RST_CH4_SDTH;
         rsvd_a_reg <= `RCCR_RST_RSVD;
         rsvd_b_reg <= `RCCR_RST_RSVD;
         ch5_rxdm_reg <= `RCCR_RST_CH5_RXDM;
         ch5_eq_reg <= `RCCR_RST_CH5_EQ;
         ch5_swing_reg <= `RCCR_RST_CH5_SWING;
      end
      else if (wr_en_i)
      begin
         // reserved bits are stored as written; software keeps them clean
         case (addr_i)
            `RCCR_OFF_CH4_SDTH: ch4_sdth_reg <= wdata_i;
            `RCCR_OFF_RSVD_A: rsvd_a_reg <= wdata_i;
            `RCCR_OFF_RSVD_B: rsvd_b_reg <= wdata_i;
            `RCCR_OFF_CH5_RXDM: ch5_rxdm_reg <= wdata_i;
            `RCCR_OFF_CH5_EQ: ch5_eq_reg <= wdata_i;
            `RCCR_OFF_CH5_SWING: ch5_swing_reg <= wdata_i;
            default:
            begin
               ch5_eq_reg <= ch5_eq_reg;
            end
         endcase
      end
   end
   always @*
   begin
      case (addr_i)
         `RCCR_OFF_CH4_SDTH: rdata_next = ch4_sdth_reg;
         `RCCR_OFF_RSVD_A: rdata_next = rsvd_a_reg;
         `RCCR_OFF_RSVD_B: rdata_next = rsvd_b_reg;
         `RCCR_OFF_CH5_RXDM: rdata_next = ch5_rxdm_reg;
         `RCCR_OFF_CH5_EQ: rdata_next = ch5_eq_reg;
         `RCCR_OFF_CH5_SWING: rdata_next = ch5_swing_reg;
         default: rdata_next = 8'h00;
      endcase
   end
   // detection sequencer; a mode change restarts it from idle
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= S_IDLE;
         mode_q_reg <= `RCCR_RXDM_HIZ;
         tmr_reg <= 32'h0;
         tries_reg <= 8'h00;
         term_50_o <= 1'b0;
         detect_test_o <= 1'b0;
      end
      else
      begin
         mode_q_reg <= mode;
         detect_test_o <= 1'b0;
         if (mode != mode_q_reg)
         begin
            state_reg <= S_IDLE;
            term_50_o <= (mode == `RCCR_RXDM_FIXED);
         end
         else
         begin
            case (state_reg)
               S_IDLE:
               begin
                  tmr_reg <= 32'h0;
                  tries_reg <= 8'h00;
                  term_50_o <= (mode == `RCCR_RXDM_FIXED);
                  if (auto_mode)
                     state_reg <= S_WAIT;
               end
               S_WAIT:
               begin
                  term_50_o <= 1'b0;
                  if (poll_end)
                  begin
                     tmr_reg <= 32'h0;
                     detect_test_o <= 1'b1;
                     if (present_s)
                     begin
                        state_reg <= S_DONE;
                        term_50_o <= 1'b1;
                     end
                     else if (tries_spent)
                        state_reg <= S_STOP;
                     else
                        tries_reg <= tries_reg + 8'h01;
                  end
                  else
                     tmr_reg <= tmr_reg + 32'h1;
               end
               S_DONE:
               begin
                  // a found receiver keeps 50 ohm until the mode moves
                  term_50_o <= 1'b1;
               end
               S_STOP:
               begin
                  term_50_o <= 1'b0;
               end
               default:
               begin
                  state_reg <= S_IDLE;
               end
            endcase
         end
      end
   end
   // outputs are registered so the pins never see decode glitches
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
         rdata_o <= 8'h00;
      else
         rdata_o <= rdata_next;
   end
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
         ch4_sdth_o <= `RCCR_RST_SDTH_OUT;
      else
         ch4_sdth_o <= sdth_eff;
   end
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
         ch5_eq_o <= `RCCR_RST_CH5_EQ;
      else
         ch5_eq_o <= ch5_eq_reg;
   end
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
         scp_en_o <= `RCCR_RST_SCP;
      else
         scp_en_o <= ch5_swing_reg[`RCCR_SWING_SCP_BIT];
   end
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
         swing_ratio_o <= `RCCR_RST_RATIO;
      else
         swing_ratio_o <= ratio_field;
   end
endmodule // rccr_channel_regs

/* rtl/rccr_regs.vh */
`ifndef RCCR_REGS_VH
`define RCCR_REGS_VH
`define RCCR_OFF_CH4_SDTH 8'h2F
`define RCCR_OFF_RSVD_A 8'h30
`define RCCR_OFF_RSVD_B 8'h31
`define RCCR_OFF_CH5_RXDM 8'h32
`define RCCR_OFF_CH5_EQ 8'h33
`define RCCR_OFF_CH5_SWING 8'h34
`define RCCR_RST_CH4_SDTH 8'h00
`define RCCR_RST_RSVD 8'h00
`define RCCR_RST_CH5_RXDM 8'h00
`define RCCR_RST_CH5_EQ 8'h2F
`define RCCR_RST_CH5_SWING 8'hAD
`define RCCR_RST_SDTH_OUT 4'h0
`define RCCR_RST_SCP 1'b1
`define RCCR_RST_RATIO 3'h5
`define RCCR_SDTH_ASSERT_MSB 3
`define RCCR_SDTH_ASSERT_LSB 2
`define RCCR_SDTH_DEASSERT_MSB 1
`define RCCR_SDTH_DEASSERT_LSB 0
`define RCCR_RXDM_MSB 3
`define RCCR_RXDM_LSB 2
`define RCCR_SWING_SCP_BIT 7
`define RCCR_SWING_RATIO_MSB 2
`define RCCR_SWING_RATIO_LSB 0
`define RCCR_RXDM_HIZ 2'h0
`define RCCR_RXDM_AUTO_LIM 2'h1
`define RCCR_RXDM_AUTO_INF 2'h2
`define RCCR_RXDM_FIXED 2'h3
`define RCCR_CLK_HZ 40000000
`define RCCR_POLL_MS 12
`define RCCR_POLL_CYC (`RCCR_CLK_HZ / 1000 * `RCCR_POLL_MS)
`define RCCR_POLL_TRIES 50
`endif

/* rtl/rccr_sync2.v */
// two-flop synchroniser for pin levels
module rccr_sync2 #(
   parameter W = 1
) (
   input wire mclk_i,
   input wire nrst_i,
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end
      else
      begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end
   assign q_o = sync_reg;
endmodule // rccr_sync2

/* verif/rccr_asserts.sv */
module rccr_asserts (
   input wire mclk_i,
   input wire nrst_i,
   input wire wr_en_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire receiver_detect_mode_ovr_i,
   input wire sdth_ovr_i,
   input wire [1:0] receiver_detect_mode_pin_i,
   input wire [3:0] sdth_pin_i,
   input wire [3:0] ch4_sdth_o,
   input wire term_50_o,
   input wire detect_test_o,
   input wire [7:0] ch5_eq_o,
   input wire scp_en_o,
   input wire [2:0] swing_ratio_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   a_ratio_wr: assert property (wr_en_i && addr_i == 8'h34 |=> ##1
      swing_ratio_o == ($past(wdata_i, 2) & 8'h07)) else $error("ratio");
   a_scp_wr: assert property (wr_en_i && addr_i == 8'h34 |=> ##1
      scp_en_o == ($past(wdata_i, 2) >> 7)) else $error("scp");
   a_eq_wr: assert property (wr_en_i && addr_i == 8'h33 |=> ##1
      ch5_eq_o == $past(wdata_i, 2)) else $error("eq");
   a_thr_reg: assert property (wr_en_i && addr_i == 8'h2F
      ##1 sdth_ovr_i [*2] |-> ch4_sdth_o == ($past(wdata_i, 2) & 8'h0F))
      else $error("thr reg");
   a_thr_pin: assert property ((!sdth_ovr_i && $stable(sdth_pin_i))
      [*6] |-> ch4_sdth_o == sdth_pin_i) else $error("thr pin");
   a_term_fixed: assert property (
      (!receiver_detect_mode_ovr_i && receiver_detect_mode_pin_i == 2'h3)
      [*8] |-> term_50_o && !detect_test_o) else $error("fixed");
   a_term_hiz: assert property (
      (!receiver_detect_mode_ovr_i && receiver_detect_mode_pin_i == 2'h0)
      [*8] |-> !term_50_o) else $error("hiz");
   a_test_gap: assert property (detect_test_o |=>
      !detect_test_o [*8]) else $error("test gap");
endmodule // rccr_asserts
bind rccr_channel_regs rccr_asserts u_chk (.*);

/* verif/rccr_rx_model.sv */
module rccr_rx_model (
   input wire mclk_i,
   input wire test_i,
   input wire [3:0] arm_i,
   output wire present_o
);
   timeunit 1ns;
   timeprecision 100ps;
   reg [3:0] cnt_reg = 4'h0;
   // receiver shows up only after arm_i tests; 0 means never there
   always @(posedge mclk_i)
      cnt_reg <= (arm_i == 4'h0) ? 4'h0 : cnt_reg + {3'h0, test_i};
   assign present_o = arm_i != 4'h0 && cnt_reg >= arm_i;
endmodule // rccr_rx_model

/* verif/test_repeater_channel_config_regs.sv */
module test_repeater_channel_config_regs;
   timeunit 1ns;
   timeprecision 100ps;
   reg mclk_i = 1'b0, nrst_i = 1'b0, wr_en_i = 1'b0;
   reg receiver_detect_mode_ovr_i = 1'b0, sdth_ovr_i = 1'b0;
   reg [7:0] addr_i = 8'h00, wdata_i = 8'h00;
   reg [3:0] sdth_pin_i = 4'h0, arm = 4'h0;
   reg [1:0] receiver_detect_mode_pin_i = 2'h0;
   wire [7:0] rdata_o, ch5_eq_o;
   wire [3:0] ch4_sdth_o;
   wire [2:0] swing_ratio_o;
   wire rx_present_i, term_50_o, detect_test_o, scp_en_o;
   integer bad_count = 0, num_checks = 0, ntest = 0, i;
   // short poll counts keep the run small
   rccr_channel_regs #(.POLL_CYC(20), .POLL_TRIES(3)) u_dut (.*);
   rccr_rx_model u_rx (.mclk_i(mclk_i), .test_i(detect_test_o),
      .arm_i(arm), .present_o(rx_present_i));
   initial forever #12.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
      if (detect_test_o === 1'b1) ntest <= ntest + 1;
   task chk(input [7:0] got, input [7:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(negedge mclk_i) {wr_en_i, addr_i, wdata_i} = {1'b1, a, d};
      @(negedge mclk_i) wr_en_i = 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(negedge mclk_i) addr_i = a;
      @(negedge mclk_i) chk(rdata_o, e);
   endtask
   task idle(input integer n);
      repeat (n) @(negedge mclk_i);
   endtask
   task t_regs;
      rd(8'h2F, 8'h00);
      rd(8'h32, 8'h00);
      rd(8'h33, 8'h2F);
      rd(8'h34, 8'hAD);
      rd(8'h30, 8'h00);
      wr(8'h30, 8'h5A);
      rd(8'h30, 8'h5A);
      rd(8'h31, 8'h00);
      wr(8'h40, 8'h77);
      rd(8'h40, 8'h00);
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(8'h34, {5'h15, i[2:0]});
         idle(2);
         chk({scp_en_o, 4'h5, swing_ratio_o}, {5'h15, i[2:0]});
      end
      wr(8'h34, 8'h2E);
      rd(8'h34, 8'h2E);
      chk({scp_en_o, 4'h5, swing_ratio_o}, 8'h2E);
      wr(8'h33, 8'h15);
      rd(8'h33, 8'h15);
      chk(ch5_eq_o, 8'h15);
   endtask
   task t_thr;
      sdth_pin_i = 4'hB;
      wr(8'h2F, 8'h06);
      idle(2);
      chk(ch4_sdth_o, 8'h0B);
      sdth_ovr_i = 1'b1;
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(8'h2F, {4'h0, i[1:0], i[1:0]});
         idle(2);
         chk(ch4_sdth_o, {4'h0, i[1:0], i[1:0]});
      end
   endtask
   task t_mode;
      receiver_detect_mode_pin_i = 2'h3;
      idle(8);
      chk(term_50_o, 1'b1);
      receiver_detect_mode_pin_i = 2'h0;
      wr(8'h32, 8'h0C);
      idle(8);
      chk(term_50_o, 1'b0);
      receiver_detect_mode_ovr_i = 1'b1;
      idle(8);
      chk(term_50_o, 1'b1);
   endtask
   task t_auto;
      wr(8'h32, 8'h04);
      ntest = 0;
      idle(200);
      chk(ntest, 8'h03);
      chk(term_50_o, 1'b0);
      arm = 4'h5;
      receiver_detect_mode_ovr_i = 1'b0;
      receiver_detect_mode_pin_i = 2'h2;
      ntest = 0;
      idle(70);
      chk(term_50_o, 1'b0);
      idle(200);
      chk(term_50_o, 1'b1);
      chk(ntest > 4, 1'b1);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #500000;
      bad_count = bad_count + 1;
      test_done;
   end
   initial
   begin
      repeat (3) @(negedge mclk_i);
      nrst_i = 1'b1;
      t_regs;
      t_thr;
      t_mode;
      t_auto;
      test_done;
   end
endmodule // test_repeater_channel_config_regs
